// ### motor_ctrl_pkg.sv
// Summary of operation
// - sleep pin low: bridge, sense amps, regulators, charge pump, serial port off
// - sleep is entered only after the sleep entry delay from the falling edge
// - sleep pin high wakes the device; controller waits the wake delay
// - fault output held low while regulators switch, released before the wake delay ends
// - sleep pin high and supply above lockout gives operating mode
// - latched faults clear by fault clear bit or sleep reset pulse
// - short low pulse in operating mode is a fault reset; longer low, or any low during wake, starts full sleep shutdown
// - reset pulse leaves regulators and register settings untouched
// - bridge disable pin high forces all bridge switches off
// - bridge disabled: supplies and serial stay on, overcurrent detection off
// - input word: rw bit 15, address 14..9, parity bit 8, data 7..0
// - output word is status byte then register data; writes return old data
// - select high: clock and data ignored, serial output released
// - sample on falling clock, launch on rising clock, msb first
// - frame not exactly 16 clocks: word dropped, frame fault latched
// - address outside the register range latches the bad address fault
// - registers return to defaults at power-up and on sleep entry
// - first status register carries the eight device fault flags
// - supply power-ok flag reads zero after a supply power-on reset
// - second status register: thermal warning, shutdown, six switch overcurrents
// - fault clear is bit 0 of control offset 4 and self-clears
// - third status register: bit 2 parity, bit 1 frame, bit 0 bad address
package motor_ctrl_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 20;
   localparam int RST_WINDOW_NS   = 20000;
   localparam int SLEEP_ENTRY_NS  = 40000;
   localparam int WAKE_NS         = 60000;
   localparam int REG_SWITCH_NS   = 10000;
   localparam int SELECT_GAP_NS   = 400;
   localparam int RST_WINDOW_CYC  = RST_WINDOW_NS / CLK_PERIOD_NS;
   localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYC        = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REG_SWITCH_CYC  = REG_SWITCH_NS / CLK_PERIOD_NS;
   localparam int SELECT_GAP_CYC  = (SELECT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // serial word layout
   // ----------------------------------------------------------------
   localparam int WORD_BITS   = 16;
   localparam int RW_BIT      = 15;
   localparam int ADDR_MSB    = 14;
   localparam int ADDR_LSB    = 9;
   localparam int PARITY_BIT  = 8;
   localparam int DATA_MSB    = 7;
   localparam int REG_COUNT   = 13;
   localparam logic [5:0] ADDR_LAST = 6'h0C;

   // ----------------------------------------------------------------
   // register offsets, fields, resets
   // ----------------------------------------------------------------
   localparam logic [5:0] OFS_FAULT_SUMMARY = 6'h00;
   localparam logic [5:0] OFS_THERMAL_SW    = 6'h01;
   localparam logic [5:0] OFS_REG_SERIAL    = 6'h02;
   localparam logic [5:0] OFS_CONTROL       = 6'h04;
   localparam int         CLEAR_BIT         = 0;
   localparam int         PARITY_ERR_BIT    = 2;
   localparam int         FRAME_ERR_BIT     = 1;
   localparam int         BAD_ADDR_BIT      = 0;
   localparam logic [7:0] STATUS_RESET      = 8'h00;
   localparam logic [7:0] CONTROL_RESET     = 8'h80;

endpackage

// ### sync2.sv
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // data
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // ----------------------------------------------------------------
   // two flip-flop synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// ### spi_link.sv
`timescale 1ns/100ps
module spi_link (
   // serial pins
   input  wire logic                                sclk,
   input  wire logic                                select_low_pin,
   input  wire logic                                sdi,
   output      logic                                sdo,
   output      logic                                sdo_oe,
   // core side, status and register inputs steady while select is low
   input  wire logic [7:0]                          status_byte,
   input  wire logic [8*motor_ctrl_pkg::REG_COUNT-1:0] reg_bytes,
   output      logic [motor_ctrl_pkg::WORD_BITS-1:0] rx_word
);

   logic [4:0] tx_idx_q;
   logic [7:0] tx_data_q;
   logic [5:0] addr;

   // address bits in place after the seventh fall
   assign addr = rx_word[motor_ctrl_pkg::ADDR_MSB-motor_ctrl_pkg::ADDR_LSB:0];

   // ----------------------------------------------------------------
   // receive
   // ----------------------------------------------------------------
   // sample on falling
   always_ff @(negedge sclk) begin
      rx_word <= {rx_word[motor_ctrl_pkg::WORD_BITS-2:0], sdi};
   end

   // ----------------------------------------------------------------
   // transmit
   // ----------------------------------------------------------------
   // launch on rising
   always_ff @(posedge sclk or posedge select_low_pin) begin
      if (select_low_pin) begin
         tx_idx_q <= 5'h00;
      end else if (tx_idx_q != 5'h10) begin
         tx_idx_q <= tx_idx_q + 5'h01;
      end
   end

   always_ff @(posedge sclk) begin
      if (tx_idx_q == 5'h07) begin
         if (addr <= motor_ctrl_pkg::ADDR_LAST) begin
            tx_data_q <= reg_bytes[8*addr[3:0] +: 8];
         end else begin
            tx_data_q <= 8'h00;
         end
      end
   end

   always_comb begin
      sdo_oe = ~select_low_pin;
      if (tx_idx_q[4]) begin
         sdo = 1'b0;
      end else if (tx_idx_q[3]) begin
         sdo = tx_data_q[3'h7 - tx_idx_q[2:0]];
      end else begin
         sdo = status_byte[3'h7 - tx_idx_q[2:0]];
      end
   end

endmodule

// ### motor_ctrl_status.sv
`timescale 1ns/100ps
module motor_ctrl_status (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // mode pins
   input  wire logic       sleep_request_low,
   input  wire logic       bridge_disable_pin,
   input  wire logic       supply_above_uvlo,
   // serial pins
   input  wire logic       sclk,
   input  wire logic       select_low_pin,
   input  wire logic       sdi,
   output      logic       sdo,
   output      logic       sdo_oe,
   // protection events
   input  wire logic       stall_event,
   input  wire logic       regulator_event,
   input  wire logic [5:0] overcurrent_event,
   input  wire logic       overvoltage_event,
   input  wire logic       thermal_warning_event,
   input  wire logic       thermal_shutdown_event,
   input  wire logic       supply_por_event,
   // power and drive controls
   output      logic       bridge_enable_q,
   output      logic       sense_amp_enable_q,
   output      logic       regulator_enable_q,
   output      logic       charge_pump_enable_q,
   output      logic       serial_enable_q,
   output      logic       ready_for_inputs_q,
   output      logic       fault_out_low_q
);

   typedef enum logic [2:0] {
      st_sleep,
      st_wake,
      st_run,
      st_low_check,
      st_entry
   } mode_e;

   mode_e       state_q;
   logic [15:0] timer_q;
   logic [3:0]  pins_s;
   logic        sleep_s;
   logic        bridge_disable_pin_s;
   logic        cs_s;
   logic        sclk_s;
   logic        cs_prev_q;
   logic        sclk_prev_q;
   logic [4:0]  frame_bits_q;
   logic [15:0] rx_word;
   logic        frame_end;
   logic        pulse_clear;
   logic        spi_clear;
   logic        clear_all;
   logic        defaults;
   logic        switching;

   // latched flags
   logic        stall_q;
   logic        regulator_q;
   logic [5:0]  overcurrent_q;
   logic        overvoltage_q;
   logic        thermal_warn_q;
   logic        thermal_shut_q;
   logic        por_seen_q;
   logic        parity_err_q;
   logic        frame_err_q;
   logic        bad_addr_q;
   logic [7:0]  control_q;

   // register views
   logic [7:0]  fault_summary;
   logic [7:0]  thermal_sw;
   logic [7:0]  reg_serial;
   logic [7:0]  status_snap_q;
   logic [8*motor_ctrl_pkg::REG_COUNT-1:0] reg_snap_q;
   logic [8*motor_ctrl_pkg::REG_COUNT-1:0] reg_view;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   sync2 #(
      .W (4)
   ) u_pin_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({sleep_request_low, bridge_disable_pin, select_low_pin, sclk}),
      .q    (pins_s)
   );

   assign sleep_s  = pins_s[3];
   assign bridge_disable_pin_s = pins_s[2];
   assign cs_s     = pins_s[1];
   assign sclk_s   = pins_s[0];

   // ----------------------------------------------------------------
   // serial link
   // ----------------------------------------------------------------
   spi_link u_link (
      .sclk           (sclk),
      .select_low_pin (select_low_pin),
      .sdi            (sdi),
      .sdo            (sdo),
      .sdo_oe         (sdo_oe),
      .status_byte    (status_snap_q),
      .reg_bytes      (reg_snap_q),
      .rx_word        (rx_word)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         cs_prev_q   <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         cs_prev_q   <= cs_s;
         sclk_prev_q <= sclk_s;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || cs_s) begin
         frame_bits_q <= 5'h00;
      end else if (sclk_prev_q && !sclk_s && frame_bits_q != 5'h1F) begin
         frame_bits_q <= frame_bits_q + 5'h01;
      end
   end

   assign frame_end = cs_s && !cs_prev_q && serial_enable_q;

   // snapshot held steady for the link while select is low
   always_ff @(posedge clk) begin
      if (srst) begin
         status_snap_q <= motor_ctrl_pkg::STATUS_RESET;
         reg_snap_q    <= '0;
      end else if (cs_s && !frame_end) begin
         status_snap_q <= fault_summary;
         reg_snap_q    <= reg_view;
      end
   end

   // ----------------------------------------------------------------
   // register views
   // ----------------------------------------------------------------
   // first status layout
   always_comb begin
      fault_summary    = motor_ctrl_pkg::STATUS_RESET;
      fault_summary[7] = stall_q;
      fault_summary[6] = regulator_q;
      fault_summary[5] = parity_err_q | frame_err_q | bad_addr_q;
      fault_summary[4] = |overcurrent_q;
      fault_summary[3] = ~por_seen_q;
      fault_summary[2] = overvoltage_q;
      fault_summary[1] = thermal_warn_q | thermal_shut_q;
      fault_summary[0] = stall_q | regulator_q | (|overcurrent_q)
                         | overvoltage_q | thermal_shut_q;
   end

   assign thermal_sw = {thermal_warn_q, thermal_shut_q, overcurrent_q};

   always_comb begin
      reg_serial = motor_ctrl_pkg::STATUS_RESET;
      reg_serial[motor_ctrl_pkg::PARITY_ERR_BIT] = parity_err_q;
      reg_serial[motor_ctrl_pkg::FRAME_ERR_BIT]  = frame_err_q;
      reg_serial[motor_ctrl_pkg::BAD_ADDR_BIT]   = bad_addr_q;
   end

   always_comb begin
      reg_view = '0;
      reg_view[8*motor_ctrl_pkg::OFS_FAULT_SUMMARY +: 8] = fault_summary;
      reg_view[8*motor_ctrl_pkg::OFS_THERMAL_SW +: 8]    = thermal_sw;
      reg_view[8*motor_ctrl_pkg::OFS_REG_SERIAL +: 8]    = reg_serial;
      reg_view[8*motor_ctrl_pkg::OFS_CONTROL +: 8]       = control_q;
   end

   // ----------------------------------------------------------------
   // word decode and write
   // ----------------------------------------------------------------
   logic       len_ok;
   logic       par_ok;
   logic       addr_ok;
   logic [5:0] word_addr;
   logic       word_write;

   assign word_addr  = rx_word[motor_ctrl_pkg::ADDR_MSB:motor_ctrl_pkg::ADDR_LSB];
   assign word_write = ~rx_word[motor_ctrl_pkg::RW_BIT];
   assign len_ok     = frame_bits_q == 5'(motor_ctrl_pkg::WORD_BITS);
   assign par_ok     = ~^rx_word;
   assign addr_ok    = word_addr <= motor_ctrl_pkg::ADDR_LAST;

   assign spi_clear = frame_end && len_ok && par_ok && addr_ok && word_write
                      && word_addr == motor_ctrl_pkg::OFS_CONTROL
                      && rx_word[motor_ctrl_pkg::CLEAR_BIT];
   assign clear_all = spi_clear | pulse_clear;
   assign defaults  = state_q == st_sleep;

   always_ff @(posedge clk) begin
      if (srst || defaults) begin
         control_q <= motor_ctrl_pkg::CONTROL_RESET;
      end else if (frame_end && len_ok && par_ok && addr_ok && word_write
                   && word_addr == motor_ctrl_pkg::OFS_CONTROL) begin
         control_q <= {rx_word[motor_ctrl_pkg::DATA_MSB:1], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (srst || defaults) begin
         frame_err_q <= 1'b0;
      end else begin
         frame_err_q <= (frame_err_q & ~clear_all) | (frame_end & ~len_ok);
      end
   end

   always_ff @(posedge clk) begin
      if (srst || defaults) begin
         parity_err_q <= 1'b0;
      end else begin
         parity_err_q <= (parity_err_q & ~clear_all) | (frame_end & len_ok & ~par_ok);
      end
   end

   always_ff @(posedge clk) begin
      if (srst || defaults) begin
         bad_addr_q <= 1'b0;
      end else begin
         bad_addr_q <= (bad_addr_q & ~clear_all) | (frame_end & len_ok & par_ok & ~addr_ok);
      end
   end

   // ----------------------------------------------------------------
   // protection flags
   // ----------------------------------------------------------------
   logic       running;
   logic [5:0] oc_gated;

   assign running  = state_q == st_run || state_q == st_low_check;
   assign oc_gated = (bridge_disable_pin_s || !running) ? 6'h00 : overcurrent_event;

   always_ff @(posedge clk) begin
      if (srst || defaults) begin
         stall_q        <= 1'b0;
         regulator_q    <= 1'b0;
         overcurrent_q  <= 6'h00;
         overvoltage_q  <= 1'b0;
         thermal_warn_q <= 1'b0;
         thermal_shut_q <= 1'b0;
      end else begin
         stall_q        <= (stall_q & ~clear_all) | stall_event;
         regulator_q    <= (regulator_q & ~clear_all) | regulator_event;
         overcurrent_q  <= (overcurrent_q & {6{~clear_all}}) | oc_gated;
         overvoltage_q  <= (overvoltage_q & ~clear_all) | overvoltage_event;
         thermal_warn_q <= (thermal_warn_q & ~clear_all) | thermal_warning_event;
         thermal_shut_q <= (thermal_shut_q & ~clear_all) | thermal_shutdown_event;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || defaults) begin
         por_seen_q <= 1'b1;
      end else begin
         por_seen_q <= (por_seen_q & ~clear_all) | supply_por_event;
      end
   end

   // ----------------------------------------------------------------
   // sleep, wake and reset pulse sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= st_sleep;
         timer_q <= 16'h0000;
      end else begin
         case (state_q)
            st_sleep: begin
               timer_q <= 16'h0000;
               if (sleep_s) begin
                  state_q <= st_wake;
               end
            end
            st_wake: begin
               timer_q <= timer_q + 16'h0001;
               if (!sleep_s) begin
                  state_q <= st_entry;
                  timer_q <= 16'h0000;
               end else if (timer_q == 16'(motor_ctrl_pkg::WAKE_CYC - 1)) begin
                  state_q <= st_run;
               end
            end
            st_run: begin
               timer_q <= 16'h0000;
               if (!sleep_s) begin
                  state_q <= st_low_check;
               end
            end
            st_low_check: begin
               timer_q <= timer_q + 16'h0001;
               // short low is a reset pulse
               if (sleep_s) begin
                  state_q <= st_run;
               end else if (timer_q == 16'(motor_ctrl_pkg::RST_WINDOW_CYC - 1)) begin
                  state_q <= st_entry;
               end
            end
            st_entry: begin
               timer_q <= timer_q + 16'h0001;
               if (timer_q >= 16'(motor_ctrl_pkg::SLEEP_ENTRY_CYC - 1)) begin
                  state_q <= st_sleep;
               end
            end
            default: begin
               state_q <= st_sleep;
               timer_q <= 16'h0000;
            end
         endcase
      end
   end

   assign pulse_clear = state_q == st_low_check && sleep_s;

   assign switching = (state_q == st_wake && timer_q < 16'(motor_ctrl_pkg::REG_SWITCH_CYC))
                      || (state_q == st_entry
                          && timer_q >= 16'(motor_ctrl_pkg::SLEEP_ENTRY_CYC - motor_ctrl_pkg::REG_SWITCH_CYC));

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic powered;
   logic latched_stop;

   assign powered      = state_q != st_sleep;
   assign latched_stop = stall_q | (|overcurrent_q) | thermal_shut_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         regulator_enable_q   <= 1'b0;
         charge_pump_enable_q <= 1'b0;
         sense_amp_enable_q   <= 1'b0;
         serial_enable_q      <= 1'b0;
         ready_for_inputs_q   <= 1'b0;
      end else begin
         regulator_enable_q   <= powered;
         charge_pump_enable_q <= powered && supply_above_uvlo;
         sense_amp_enable_q   <= running && supply_above_uvlo;
         // serial stays on with bridge disabled
         serial_enable_q      <= powered;
         ready_for_inputs_q   <= running && supply_above_uvlo;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bridge_enable_q <= 1'b0;
      end else begin
         bridge_enable_q <= running && supply_above_uvlo && !bridge_disable_pin_s && !latched_stop;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         fault_out_low_q <= 1'b0;
      end else begin
         fault_out_low_q <= !(switching || (running && fault_summary[0]));
      end
   end

endmodule

// ### spi_ctrl_model.sv
`timescale 1ns/100ps
module spi_ctrl_model (
   // serial pins
   output logic      sclk,
   output logic      select_low_pin,
   output logic      sdi,
   input  wire logic sdo_w
);
   initial begin
      sclk = 1'b0;
      sdi = 1'b0;
      // clean select rise clears the link bit index
      select_low_pin = 1'b0;
      #1;
      select_low_pin = 1'b1;
   end
   // -------------------------------------------
   // one frame of n clocks, 125 ns period
   // -------------------------------------------
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      int i;
      r = 16'h0000;
      #7.3;
      sdi = w[15];
      select_low_pin = 1'b0;
      #62.5;
      for (i = 0; i < n; i++) begin
         r = {r[14:0], sdo_w};
         sclk = 1'b1;
         if (i > 0 && i < 16) begin
            sdi = w[15-i];
         end else if (i >= 16) begin
            sdi = ~sdi;
         end
         #62.5;
         sclk = 1'b0;
         #62.5;
      end
      select_low_pin = 1'b1;
      sdi = ~sdi;
      #1000;
   endtask
endmodule

// ### motor_ctrl_status_chk.sv
`timescale 1ns/100ps
module motor_ctrl_status_chk (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pins
   input wire logic sleep_request_low,
   input wire logic bridge_disable_pin,
   input wire logic supply_above_uvlo,
   input wire logic select_low_pin,
   input wire logic sdo_oe,
   // outputs
   input wire logic bridge_enable_q,
   input wire logic sense_amp_enable_q,
   input wire logic regulator_enable_q,
   input wire logic charge_pump_enable_q,
   input wire logic serial_enable_q,
   input wire logic ready_for_inputs_q,
   input wire logic fault_out_low_q
);
   logic [11:0] low_cnt_q;
   logic [11:0] high_cnt_q;
   always_ff @(posedge clk) begin
      if (srst || sleep_request_low) low_cnt_q <= 12'h000;
      else if (low_cnt_q != 12'hFFF) low_cnt_q <= low_cnt_q + 12'h001;
   end
   always_ff @(posedge clk) begin
      if (srst || !sleep_request_low || !supply_above_uvlo) high_cnt_q <= 12'h000;
      else if (high_cnt_q != 12'hFFF) high_cnt_q <= high_cnt_q + 12'h001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence sleep_fall;
      $fell(sleep_request_low) ##0 regulator_enable_q;
   endsequence
   sequence supplies_hold;
      regulator_enable_q [*8];
   endsequence
   a_sel_release: assert property (select_low_pin |-> !sdo_oe)
      else $error("serial output driven while deselected");
   a_sel_drive: assert property (!select_low_pin |-> sdo_oe)
      else $error("serial output not driven while selected");
   a_bridge_off: assert property (bridge_disable_pin [*4] |-> !bridge_enable_q)
      else $error("bridge enabled while disabled by pin");
   a_supplies_on: assert property (sleep_request_low && ready_for_inputs_q |->
      serial_enable_q && charge_pump_enable_q && regulator_enable_q)
      else $error("supplies off in operating mode");
   a_entry_hold: assert property (sleep_fall |=> supplies_hold)
      else $error("sleep entered too early");
   a_sleep_off: assert property (low_cnt_q >= 12'(motor_ctrl_pkg::SLEEP_ENTRY_CYC + 10) |->
      !(bridge_enable_q || sense_amp_enable_q || regulator_enable_q || charge_pump_enable_q
      || serial_enable_q || ready_for_inputs_q))
      else $error("block still powered in sleep");
   a_wake_ready: assert property (high_cnt_q >= 12'(motor_ctrl_pkg::WAKE_CYC + 100) |-> ready_for_inputs_q)
      else $error("not ready after wake delay");
   a_fault_release: assert property ($rose(ready_for_inputs_q) |-> fault_out_low_q)
      else $error("fault output still low after wake");
endmodule
bind motor_ctrl_status motor_ctrl_status_chk motor_ctrl_status_chk_i (.clk, .srst, .sleep_request_low,
   .bridge_disable_pin, .supply_above_uvlo, .select_low_pin, .sdo_oe, .bridge_enable_q, .sense_amp_enable_q,
   .regulator_enable_q, .charge_pump_enable_q, .serial_enable_q, .ready_for_inputs_q, .fault_out_low_q);

// ### motor_ctrl_status_tb.sv
`timescale 1ns/100ps
module motor_ctrl_status_tb;
   logic clk = 1'b0, srst = 1'b1, sleep_request_low = 1'b1, bridge_disable_pin = 1'b0;
   logic supply_above_uvlo = 1'b1, sclk, select_low_pin, sdi, sdo, sdo_oe;
   logic stall_event = 1'b0, regulator_event = 1'b0, overvoltage_event = 1'b0;
   logic thermal_warning_event = 1'b0, thermal_shutdown_event = 1'b0, supply_por_event = 1'b0;
   logic [5:0] overcurrent_event = 6'h00;
   logic bridge_enable_q, sense_amp_enable_q, regulator_enable_q, charge_pump_enable_q;
   logic serial_enable_q, ready_for_inputs_q, fault_out_low_q;
   int fails = 0, comparisons = 0, cycles = 0;
   wire sdo_w = sdo_oe ? sdo : 1'bz;
   always #10 clk = ~clk;
   motor_ctrl_status motor_ctrl_status_i (.clk, .srst, .sleep_request_low, .bridge_disable_pin,
      .supply_above_uvlo, .sclk, .select_low_pin, .sdi, .sdo, .sdo_oe, .stall_event, .regulator_event,
      .overcurrent_event, .overvoltage_event, .thermal_warning_event, .thermal_shutdown_event,
      .supply_por_event, .bridge_enable_q, .sense_amp_enable_q, .regulator_enable_q, .charge_pump_enable_q,
      .serial_enable_q, .ready_for_inputs_q, .fault_out_low_q);
   spi_ctrl_model spi_ctrl_model_i (.sclk, .select_low_pin, .sdi, .sdo_w);
   // -------------------------------------------
   // helpers
   // -------------------------------------------
   task automatic complete_run;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         complete_run();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic xfer(input logic rw, input logic [5:0] a, input logic [7:0] d, input logic bad,
                       input int n, input logic [15:0] exp);
      logic [15:0] w;
      logic [15:0] r;
      w = {rw, a, 1'b0, d};
      w[8] = (^w) ^ bad;
      spi_ctrl_model_i.xfer(w, n, r);
      if (n == 16) chk16(r, exp);
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      xfer(1'b1, a, 8'h00, 1'b0, 16, exp);
   endtask
   task automatic wait_ready;
      int i;
      for (i = 0; i < 4000 && ready_for_inputs_q !== 1'b1; i++) cyc(1);
      chk1(ready_for_inputs_q, 1'b1);
   endtask
   // -------------------------------------------
   // scenarios
   // -------------------------------------------
   initial begin
      cyc(20);
      srst <= 1'b0;
      wait_ready();
      rd(6'h00, 16'h0000);
      rd(6'h01, 16'h0000);
      rd(6'h02, 16'h0000);
      rd(6'h04, 16'h0080);
      xfer(1'b0, 6'h04, 8'h54, 1'b0, 16, 16'h0080);
      rd(6'h04, 16'h0054);
      xfer(1'b0, 6'h01, 8'hFF, 1'b0, 16, 16'h0000);
      rd(6'h01, 16'h0000);
      rd(6'h0D, 16'h0000);
      rd(6'h02, 16'h2001);
      xfer(1'b0, 6'h04, 8'h55, 1'b0, 16, 16'h2054);
      rd(6'h02, 16'h0800);
      rd(6'h04, 16'h0854);
      xfer(1'b1, 6'h00, 8'h00, 1'b0, 15, 16'h0000);
      rd(6'h02, 16'h2802);
      xfer(1'b0, 6'h04, 8'h55, 1'b0, 16, 16'h2854);
      xfer(1'b1, 6'h00, 8'h00, 1'b0, 17, 16'h0000);
      rd(6'h02, 16'h2802);
      xfer(1'b0, 6'h04, 8'h00, 1'b1, 16, 16'h2854);
      rd(6'h02, 16'h2806);
      rd(6'h04, 16'h2854);
      cyc(1);
      sleep_request_low <= 1'b0;
      cyc(500);
      sleep_request_low <= 1'b1;
      cyc(10);
      rd(6'h02, 16'h0800);
      rd(6'h04, 16'h0854);
      chk1(ready_for_inputs_q, 1'b1);
      cyc(1);
      bridge_disable_pin <= 1'b1;
      cyc(5);
      overcurrent_event <= 6'h21;
      cyc(1);
      overcurrent_event <= 6'h00;
      cyc(4);
      rd(6'h01, 16'h0800);
      cyc(1);
      bridge_disable_pin <= 1'b0;
      cyc(5);
      chk1(bridge_enable_q, 1'b1);
      {stall_event, regulator_event, overvoltage_event} <= 3'h7;
      {thermal_warning_event, thermal_shutdown_event, supply_por_event} <= 3'h7;
      overcurrent_event <= 6'h21;
      cyc(1);
      {stall_event, regulator_event, overvoltage_event} <= 3'h0;
      {thermal_warning_event, thermal_shutdown_event, supply_por_event} <= 3'h0;
      overcurrent_event <= 6'h00;
      cyc(5);
      chk1(fault_out_low_q, 1'b0);
      chk1(bridge_enable_q, 1'b0);
      rd(6'h01, 16'hD7E1);
      xfer(1'b0, 6'h04, 8'h55, 1'b0, 16, 16'hD754);
      rd(6'h00, 16'h0808);
      chk1(fault_out_low_q, 1'b1);
      chk1(bridge_enable_q, 1'b1);
      cyc(1);
      sleep_request_low <= 1'b0;
      cyc(1800);
      chk1(fault_out_low_q, 1'b0);
      cyc(300);
      chk1(ready_for_inputs_q, 1'b0);
      chk1(fault_out_low_q, 1'b1);
      sleep_request_low <= 1'b1;
      wait_ready();
      rd(6'h04, 16'h0080);
      complete_run();
   end
endmodule
